// ===== rtl/sfmf_params.svh
// Constants of the speech-feature multiframe framer
`ifndef SFMF_PARAMS_SVH
`define SFMF_PARAMS_SVH

// Register map (byte addresses on APB)
`define SFMF_ADDR_W 12
`define SFMF_OFF_CTRL 12'h000
`define SFMF_OFF_STATUS 12'h004

// Control register fields
`define SFMF_CTRL_ENABLE 0
`define SFMF_CTRL_VARIANT 1
`define SFMF_CTRL_RATE_LO 2
`define SFMF_CTRL_RATE_HI 3
`define SFMF_CTRL_EXT 4
`define SFMF_CTRL_FILL 5
`define SFMF_CTRL_FINAL 6
`define SFMF_CTRL_RST 7'h00
`define SFMF_RATE_UNDEF 2'h2

// Status register fields
`define SFMF_STAT_CNT_LO 0
`define SFMF_STAT_CNT_HI 3
`define SFMF_STAT_BUSY 4
`define SFMF_STAT_DONE 5
`define SFMF_STAT_LVL_LO 6
`define SFMF_STAT_LVL_HI 10

// Sync words, first octet sent first, each octet bit 1 first
`define SFMF_SYNC_OCT1 8'h87
`define SFMF_SYNC_OCT2 8'hb2
`define SFMF_ISYNC_OCT1 8'h78
`define SFMF_ISYNC_OCT2 8'h4d

// Segment lengths in bits and packets per multiframe, stored as length minus one, and the first multiframe count
`define SFMF_SYNC_LAST 7'h0f
`define SFMF_HDR_LAST 7'h1f
`define SFMF_PKT_LAST 7'h6b
`define SFMF_PKTS_LAST 4'hb
`define SFMF_MFCNT_FIRST 4'h1

// Check polynomials
`define SFMF_HDR_POLY 15'h5101
`define SFMF_CB_POLY 4'h3
`define SFMF_PC_POLY 2'h3

// Line rate
`define SFMF_CLK_HZ 100000000
`define SFMF_LINE_BPS 5600
`define SFMF_BIT_CYCLES (`SFMF_CLK_HZ / `SFMF_LINE_BPS)

// Buffering
`define SFMF_FIFO_DEPTH 16
`define SFMF_PAIR_W 102

`endif

// ===== rtl/sfmf_pkg.sv
// Types of the speech-feature multiframe framer
`default_nettype none
package sfmf_pkg;

	typedef enum logic [2:0] {
		SFMF_IDLE,
		SFMF_SYNC,
		SFMF_HDR,
		SFMF_PKT,
		SFMF_FILL
	} sfmf_state_t;

	typedef struct packed {
		logic enable;
		logic variant;
		logic [1:0] rate_code;
		logic ext;
		logic fill_en;
		logic final_req;
		logic done;
		sfmf_state_t st;
		logic [107:0] sh;
		logic [6:0] bitcnt;
		logic [3:0] pkt;
		logic [3:0] mf_cnt;
		logic have;
		logic zero_seen;
		logic [14:0] gap;
		logic [31:0] prdata;
	} sfmf_regs_t;

	typedef struct packed {
		logic [3:0] wr;
		logic [3:0] rd;
		logic [4:0] count;
	} sfmf_fifo_ptr_t;

endpackage : sfmf_pkg
`default_nettype wire

// ===== rtl/sfmf_framer.sv
// Speech-feature multiframe framer with APB control and input FIFO
//
// Decided for this implementation: the address map and the APB register port.
`default_nettype none
`include "sfmf_params.svh"

module sfmf_fifo
	import sfmf_pkg::*;
#(
	parameter int WIDTH = `SFMF_PAIR_W,
	parameter int DEPTH = `SFMF_FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [4:0] level
);
	// Pointer widths match the fixed depth of sixteen
	logic [WIDTH-1:0] mem [DEPTH];
	sfmf_fifo_ptr_t p_ff;
	sfmf_fifo_ptr_t nxt_p;
	logic push;
	logic pop;

	// Full and empty follow the count, so a push and a pop in one cycle leave the level as it was
	assign in_ready = (p_ff.count != 5'(DEPTH));
	assign out_valid = (p_ff.count != 5'h00);
	assign out_data = mem[p_ff.rd];
	assign level = p_ff.count;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// A full queue refuses pushes, so the source holds its pair until room frees
	always_comb begin
		nxt_p = p_ff;
		if (push) begin
			nxt_p.wr = p_ff.wr + 4'h1;
		end
		if (pop) begin
			nxt_p.rd = p_ff.rd + 4'h1;
		end
		nxt_p.count = p_ff.count + 5'(push) - 5'(pop);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_ff <= '0;
		end else begin
			p_ff <= nxt_p;
		end
	end

	// Storage carries no reset; only the pointers decide what is valid
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[p_ff.wr] <= in_data;
		end
	end
endmodule : sfmf_fifo

module sfmf_framer
	import sfmf_pkg::*;
#(
	parameter int BIT_CYCLES = `SFMF_BIT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`SFMF_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fp_valid,
	output logic fp_ready,
	input wire logic [43:0] fp_codebook0,
	input wire logic [43:0] fp_codebook1,
	input wire logic [6:0] fp_pitch0,
	input wire logic [4:0] fp_pitch1,
	input wire logic fp_class0,
	input wire logic fp_class1,
	output logic ser_bit,
	output logic ser_valid,
	input wire logic ser_ready
);
	sfmf_regs_t r_ff;
	sfmf_regs_t nxt_r;
	logic q_valid;
	logic q_pop;
	logic [`SFMF_PAIR_W-1:0] q_data;
	logic [4:0] q_level;
	logic addr_ok;
	logic wr_ctrl;
	logic wr_stat;
	logic bit_go;
	logic [31:0] status;

	// Pairs queue here so the source need not wait for the slow line
	sfmf_fifo #(
		.WIDTH(`SFMF_PAIR_W),
		.DEPTH(`SFMF_FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(fp_valid),
		.in_ready(fp_ready),
		.in_data({fp_class1, fp_class0, fp_pitch1, fp_pitch0, fp_codebook1, fp_codebook0}),
		.out_valid(q_valid),
		.out_ready(q_pop),
		.out_data(q_data),
		.level(q_level)
	);

	// Codebook check, message fed in send order, first bit as top term
	function automatic logic [3:0] cb_check(input logic [87:0] m);
		logic [3:0] c;
		logic fb;
		c = 4'h0;
		for (int i = 0; i < 88; i++) begin
			fb = m[i] ^ c[3];
			c = {c[2:0], 1'b0} ^ (fb ? `SFMF_CB_POLY : 4'h0);
		end
		return c;
	endfunction : cb_check

	// Pitch and class check, same convention as the codebook check
	function automatic logic [1:0] pc_check(input logic [13:0] m);
		logic [1:0] c;
		logic fb;
		c = 2'h0;
		for (int i = 0; i < 14; i++) begin
			fb = m[i] ^ c[1];
			c = {c[0], 1'b0} ^ (fb ? `SFMF_PC_POLY : 2'h0);
		end
		return c;
	endfunction : pc_check

	// Packet in send order: index 0 leaves the line first
	function automatic logic [107:0] build_pkt(input logic [`SFMF_PAIR_W-1:0] d);
		logic [107:0] p;
		logic [3:0] c4;
		logic [1:0] c2;
		p = '0;
		p[87:0] = d[87:0];
		c4 = cb_check(p[87:0]);
		p[91:88] = {c4[0], c4[1], c4[2], c4[3]};
		p[98:92] = d[94:88];
		p[103:99] = d[99:95];
		p[104] = d[100];
		p[105] = d[101];
		c2 = pc_check(p[105:92]);
		p[107:106] = {c2[0], c2[1]};
		return p;
	endfunction : build_pkt

	// Header: 16 message bits, 15 cyclic parity bits, overall even parity
	function automatic logic [31:0] build_hdr(input logic [1:0] rate, input logic var_b,
		input logic [3:0] cnt, input logic ext);
		logic [31:0] h;
		logic [14:0] c;
		logic fb;
		h = '0;
		h[1:0] = rate;
		h[2] = var_b;
		h[6:3] = cnt;
		h[7] = ext;
		h[15:8] = 8'h00;
		c = 15'h0000;
		for (int i = 0; i < 16; i++) begin
			fb = h[i] ^ c[14];
			c = {c[13:0], 1'b0} ^ (fb ? `SFMF_HDR_POLY : 15'h0000);
		end
		// Remainder top term first, as parity bits 1 to 15
		for (int j = 0; j < 15; j++) begin
			h[16 + j] = c[14 - j];
		end
		h[31] = ^h[30:0];
		return h;
	endfunction : build_hdr

	// Zero wait states: each access ends in the cycle after its setup
	assign addr_ok = (paddr == `SFMF_OFF_CTRL) || (paddr == `SFMF_OFF_STATUS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = r_ff.prdata;
	assign wr_ctrl = psel && penable && pwrite && pstrb[0] && (paddr == `SFMF_OFF_CTRL);
	assign wr_stat = psel && penable && pwrite && pstrb[0] && (paddr == `SFMF_OFF_STATUS);

	// Output stalls whenever the pacing gap runs or the line is not ready
	assign ser_valid = r_ff.have && (r_ff.st != SFMF_IDLE) && (r_ff.gap == 15'h0000);
	assign ser_bit = r_ff.sh[0];
	assign bit_go = ser_valid && ser_ready;
	// Once zero padding began, later pairs wait for the next run
	assign q_pop = (r_ff.st == SFMF_PKT) && !r_ff.have && !r_ff.zero_seen && q_valid;

	// Status reflects live state; a read captures it at its setup edge
	always_comb begin
		status = 32'h0000_0000;
		status[`SFMF_STAT_CNT_HI:`SFMF_STAT_CNT_LO] = r_ff.mf_cnt;
		status[`SFMF_STAT_BUSY] = (r_ff.st != SFMF_IDLE);
		status[`SFMF_STAT_DONE] = r_ff.done;
		status[`SFMF_STAT_LVL_HI:`SFMF_STAT_LVL_LO] = q_level;
	end

	always_comb begin
		nxt_r = r_ff;

		// Read data captured in the setup phase, valid through the access phase
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`SFMF_OFF_CTRL: nxt_r.prdata = {25'h0, r_ff.final_req, r_ff.fill_en, r_ff.ext,
					r_ff.rate_code, r_ff.variant, r_ff.enable};
				`SFMF_OFF_STATUS: nxt_r.prdata = status;
				default: nxt_r.prdata = 32'h0000_0000;
			endcase
		end

		// Writes land at the access edge, where pready is already high
		if (wr_ctrl) begin
			nxt_r.enable = pwdata[`SFMF_CTRL_ENABLE];
			nxt_r.variant = pwdata[`SFMF_CTRL_VARIANT];
			// The undefined rate code must never reach a header, so such a write keeps the old code
			if (pwdata[`SFMF_CTRL_RATE_HI:`SFMF_CTRL_RATE_LO] != `SFMF_RATE_UNDEF) begin
				nxt_r.rate_code = pwdata[`SFMF_CTRL_RATE_HI:`SFMF_CTRL_RATE_LO];
			end
			nxt_r.ext = pwdata[`SFMF_CTRL_EXT];
			nxt_r.fill_en = pwdata[`SFMF_CTRL_FILL];
			nxt_r.final_req = pwdata[`SFMF_CTRL_FINAL];
		end

		if (wr_stat && pwdata[`SFMF_STAT_DONE]) begin
			nxt_r.done = 1'b0;
		end

		// Gap counts the cycles left before the next bit may be offered
		if (r_ff.gap != 15'h0000) begin
			nxt_r.gap = r_ff.gap - 15'h0001;
		end

		unique case (r_ff.st)
			SFMF_IDLE: begin
				// While disabled the next run starts numbering afresh
				if (!r_ff.enable) begin
					nxt_r.mf_cnt = `SFMF_MFCNT_FIRST;
				end
				// A queued pair or a pending final request opens a multiframe at once
				if (r_ff.enable && (q_valid || r_ff.final_req)) begin
					nxt_r.st = SFMF_SYNC;
					nxt_r.sh = {92'h0, `SFMF_SYNC_OCT2, `SFMF_SYNC_OCT1};
					nxt_r.bitcnt = `SFMF_SYNC_LAST;
					nxt_r.have = 1'b1;
					nxt_r.zero_seen = 1'b0;
				end else if (r_ff.enable && r_ff.fill_en) begin
					// Fill only while nothing waits, so a ready multiframe waits at most for the rest of one fill word
					nxt_r.st = SFMF_FILL;
					nxt_r.sh = {92'h0, `SFMF_ISYNC_OCT2, `SFMF_ISYNC_OCT1};
					nxt_r.bitcnt = `SFMF_SYNC_LAST;
					nxt_r.have = 1'b1;
				end
			end
			SFMF_PKT: begin
				// Queued pairs come first; zeros only once the queue ran dry under a final request
				if (!r_ff.have) begin
					if (q_pop) begin
						nxt_r.sh = build_pkt(q_data);
						nxt_r.bitcnt = `SFMF_PKT_LAST;
						nxt_r.have = 1'b1;
					end else if (r_ff.final_req || r_ff.zero_seen) begin
						nxt_r.sh = '0;
						nxt_r.bitcnt = `SFMF_PKT_LAST;
						nxt_r.have = 1'b1;
						nxt_r.zero_seen = 1'b1;
					end
				end
			end
			default: begin
			end
		endcase

		// Each accepted bit restarts the pacing gap and moves the shifter on
		if (bit_go) begin
			nxt_r.gap = 15'(BIT_CYCLES - 1);
			if (r_ff.bitcnt != 7'h00) begin
				nxt_r.sh = {1'b0, r_ff.sh[107:1]};
				nxt_r.bitcnt = r_ff.bitcnt - 7'h01;
			end else begin
				unique case (r_ff.st)
					SFMF_SYNC: begin
						// Header takes the control fields as they stand when the sync word ends
						nxt_r.st = SFMF_HDR;
						nxt_r.sh = {76'h0, build_hdr(r_ff.rate_code, r_ff.variant, r_ff.mf_cnt,
							r_ff.ext)};
						nxt_r.bitcnt = `SFMF_HDR_LAST;
					end
					SFMF_HDR: begin
						// Payload starts empty; the next cycle loads the first packet
						nxt_r.st = SFMF_PKT;
						nxt_r.pkt = 4'h0;
						nxt_r.have = 1'b0;
					end
					SFMF_PKT: begin
						nxt_r.have = 1'b0;
						nxt_r.pkt = r_ff.pkt + 4'h1;
						// Last packet: count on, or restart at one after the final multiframe
						if (r_ff.pkt == `SFMF_PKTS_LAST) begin
							nxt_r.st = SFMF_IDLE;
							nxt_r.mf_cnt = r_ff.mf_cnt + 4'h1;
							if (r_ff.zero_seen) begin
								nxt_r.done = 1'b1;
								nxt_r.final_req = 1'b0;
								nxt_r.mf_cnt = `SFMF_MFCNT_FIRST;
							end
						end
					end
					SFMF_FILL: begin
						// A fill word always runs to its end, so the line never carries a cut word
						nxt_r.st = SFMF_IDLE;
						nxt_r.have = 1'b0;
					end
					default: begin
						nxt_r.st = SFMF_IDLE;
						nxt_r.have = 1'b0;
					end
				endcase
			end
		end

		// Software setting the final request wins over the hardware clear
		if (wr_ctrl && pwdata[`SFMF_CTRL_FINAL]) begin
			nxt_r.final_req = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Counter starts at one so the first multiframe after reset carries 0001
			r_ff <= '{enable: 1'b0, variant: 1'b0, rate_code: 2'h0, ext: 1'b0, fill_en: 1'b0,
				final_req: 1'b0, done: 1'b0, st: SFMF_IDLE, sh: '0, bitcnt: 7'h00, pkt: 4'h0,
				mf_cnt: `SFMF_MFCNT_FIRST, have: 1'b0, zero_seen: 1'b0, gap: 15'h0000,
				prdata: 32'h0000_0000};
		end else begin
			r_ff <= nxt_r;
		end
	end
endmodule : sfmf_framer
`default_nettype wire

// ===== bench/sfmf_framer_monitor.sv
// Port-level assertion checker for the multiframe framer
`default_nettype none
module sfmf_framer_monitor #(
	parameter int BIT_CYCLES = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ser_bit,
	input wire logic ser_valid,
	input wire logic ser_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] SYNC_BITS = 16'hb287;
	localparam logic [15:0] FILL_BITS = 16'h4d78;
	logic [10:0] pos_ff;
	logic [3:0] fpos_ff;
	logic par_ff;
	logic fill_ff;
	logic acc;
	logic bad_addr;
	assign acc = ser_valid && ser_ready;
	assign bad_addr = paddr != 12'h000 && paddr != 12'h004;
	// Position assumes back-to-back multiframes; fill is only switched on between multiframes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_ff <= 11'h000;
			fpos_ff <= 4'h0;
			par_ff <= 1'b0;
			fill_ff <= 1'b0;
		end else begin
			if (psel && penable && pready && pwrite && paddr == 12'h000) begin
				fill_ff <= pwdata[5];
			end
			if (acc && fill_ff) begin
				fpos_ff <= fpos_ff + 4'h1;
			end
			if (acc && !fill_ff) begin
				pos_ff <= (pos_ff == 11'h53f) ? 11'h000 : pos_ff + 11'h001;
				par_ff <= (pos_ff == 11'h010) ? ser_bit : par_ff ^ ser_bit;
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	stall_hold_a: assert property (ser_valid && !ser_ready |=> ser_valid && $stable(ser_bit))
		else $error("serial bit changed while stalled");
	bit_gap_a: assert property (BIT_CYCLES > 1 && acc |=> !ser_valid)
		else $error("bit offered too soon");
	sync_word_a: assert property (acc && !fill_ff && pos_ff < 11'd16 |-> ser_bit == SYNC_BITS[pos_ff[3:0]])
		else $error("sync bit wrong");
	fill_word_a: assert property (acc && fill_ff |-> ser_bit == FILL_BITS[fpos_ff])
		else $error("fill bit wrong");
	spare_zero_a: assert property (acc && !fill_ff && pos_ff >= 11'd24 && pos_ff < 11'd32 |-> !ser_bit)
		else $error("spare bit not zero");
	hdr_parity_a: assert property (acc && !fill_ff && pos_ff == 11'd47 |-> ser_bit == par_ff)
		else $error("header overall parity odd");
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("access phase not ready");
	apb_err_a: assert property (psel && penable && bad_addr |-> pslverr)
		else $error("unmapped access without error");
	apb_rdzero_a: assert property (psel && penable && !pwrite && bad_addr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	stall_c: cover property (ser_valid && !ser_ready);
	hdr_end_c: cover property (acc && pos_ff == 11'd47);
	apb_err_c: cover property (psel && penable && pslverr);
	fill_c: cover property (acc && fill_ff);
endmodule : sfmf_framer_monitor
bind sfmf_framer sfmf_framer_monitor #(.BIT_CYCLES(BIT_CYCLES)) i_mon (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.pready(pready),
	.pslverr(pslverr), .ser_bit(ser_bit), .ser_valid(ser_valid), .ser_ready(ser_ready));
`default_nettype wire

// ===== bench/sfmf_line_sink.sv
// Serial line sink standing in for the remote decoder
`default_nettype none
module sfmf_line_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ser_bit,
	input wire logic ser_valid,
	input wire logic stall,
	output logic ser_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rx_q[$];
	// Toggling readiness makes the framer hold any bit offered while ser_ready is low
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_ready <= 1'b0;
		end else begin
			ser_ready <= stall ? ~ser_ready : 1'b1;
			if (ser_valid && ser_ready) begin
				rx_q.push_back(ser_bit);
			end
		end
	end
endmodule : sfmf_line_sink
`default_nettype wire

// ===== bench/sfmf_framer_tb.sv
// Testbench for the multiframe framer
`default_nettype none
module sfmf_framer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, fp_valid, fp_ready, stall, err;
	logic pready, pslverr, ser_bit, ser_valid, ser_ready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [43:0] cb0, cb1, a, b;
	logic [6:0] pt0, p;
	logic [4:0] pt1, q;
	logic [1:0] cl, c;
	logic exp_q[$];
	int num_errors = 0;
	int n_tests = 0;
	int mism;
	sfmf_framer #(.BIT_CYCLES(2)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fp_valid(fp_valid), .fp_ready(fp_ready), .fp_codebook0(cb0), .fp_codebook1(cb1),
		.fp_pitch0(pt0), .fp_pitch1(pt1), .fp_class0(cl[0]), .fp_class1(cl[1]), .ser_bit(ser_bit),
		.ser_valid(ser_valid), .ser_ready(ser_ready));
	sfmf_line_sink i_sink (.pclk(pclk), .presetn(presetn), .ser_bit(ser_bit), .ser_valid(ser_valid),
		.stall(stall), .ser_ready(ser_ready));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic final_report();
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, want);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100) begin
			num_errors++;
			final_report();
		end
		@(posedge pclk);
	endtask : apb
	task automatic fields(input int k, input logic z);
		a = z ? 44'h0 : {k[3:0], 40'ha5c30f96e1};
		b = z ? 44'h0 : {40'h1e69f03c5a, k[3:0]};
		p = z ? 7'h00 : 7'(k * 9 + 3);
		q = z ? 5'h00 : 5'(k + 17);
		c = z ? 2'h0 : k[1:0];
	endtask : fields
	task automatic put(input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(v[i]);
		end
	endtask : put
	// Check values go out top term first
	task automatic putc(input logic [14:0] r, input int w);
		for (int i = w - 1; i >= 0; i--) begin
			exp_q.push_back(r[i]);
		end
	endtask : putc
	function automatic logic [14:0] crc(input int s, input int n, input int w, input logic [14:0] poly);
		logic [14:0] r = 15'h0000;
		logic fb;
		for (int i = s; i < s + n; i++) begin
			fb = exp_q[i] ^ r[w-1];
			r = (r << 1) & ((15'h0001 << w) - 15'h0001);
			if (fb) r = r ^ poly;
		end
		return r;
	endfunction : crc
	task automatic mf(input logic [3:0] cnt, input int first, input int nd);
		int h;
		logic par = 1'b0;
		put(64'h87, 8);
		put(64'hb2, 8);
		h = exp_q.size();
		put({56'h0, 1'b1, cnt, 1'b1, 2'b11}, 8);
		put(64'h0, 8);
		putc(crc(h, 16, 15, 15'h5101), 15);
		for (int i = h; i < h + 31; i++) par = par ^ exp_q[i];
		exp_q.push_back(par);
		for (int k = 0; k < 12; k++) begin
			fields(first + k, k >= nd);
			h = exp_q.size();
			put(64'(a), 44);
			put(64'(b), 44);
			putc(crc(h, 88, 4, 15'h0003), 4);
			h = exp_q.size();
			put(64'(p), 7);
			put(64'(q), 5);
			put(64'(c), 2);
			putc(crc(h, 14, 2, 15'h0003), 2);
		end
	endtask : mf
	task automatic wait_bits(input int n);
		int t = 0;
		while (i_sink.rx_q.size() < n && t < 50000) begin
			@(posedge pclk);
			t++;
		end
		if (t >= 50000) begin
			num_errors++;
			final_report();
		end
	endtask : wait_bits
	initial begin
		{presetn, psel, penable, pwrite, fp_valid, stall, paddr, pwdata} = '0;
		{cb0, cb1, pt0, pt1, cl} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 12'h008, 32'hff);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h000, 32'h0a);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h2);
		// Seventeenth pair is offered too and must be refused while full
		for (int k = 0; k < 17; k++) begin
			fields(k, 1'b0);
			{cb0, cb1, pt0, pt1, cl} <= {a, b, p, q, c};
			fp_valid <= 1'b1;
			@(posedge pclk);
			chk({31'h0, fp_ready}, {31'h0, k < 16});
		end
		fp_valid <= 1'b0;
		apb(1'b0, 12'h004, 32'h0);
		chk(rd & 32'h7ff, 32'h401);
		stall <= 1'b1;
		apb(1'b1, 12'h000, 32'h1f);
		wait_bits(1400);
		apb(1'b1, 12'h000, 32'h5f);
		wait_bits(2688);
		repeat (40) @(posedge pclk);
		mf(4'h1, 0, 12);
		mf(4'h2, 12, 4);
		mism = 0;
		for (int i = 0; i < 2688; i++) mism += (i_sink.rx_q[i] !== exp_q[i]);
		chk(mism, 0);
		chk(i_sink.rx_q.size(), 2688);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd & 32'h7ff, 32'h21);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1f);
		// Idle with nothing queued: fill words keep the line busy
		apb(1'b1, 12'h000, 32'h21);
		wait_bits(2720);
		put(64'h4d78_4d78, 32);
		mism = 0;
		for (int i = 2688; i < 2720; i++) mism += (i_sink.rx_q[i] !== exp_q[i]);
		chk(mism, 0);
		final_report();
	end
endmodule : sfmf_framer_tb
`default_nettype wire
